//--- rtl/ledsd_pkg.sv
// Notes on behaviour
// - captured data bit 7 at mode load picks minimum (0) or maximum (1) display.
// - minimum mode shows four hub-wide flags: jabber, any collision, reception, partition.
// - minimum mode: collision bit 1, reception bit 2, jabber bit 3, partition bit 4.
// - minimum mode pulses lower strobe for one octal latch; upper strobe stays high.
// - maximum mode: link bit 0, collision 1, reception 2, inverse polarity bit 4.
// - inverse polarity is shown only for ports using the internal transceiver.
// - maximum mode puts the port's latch address on bits 7 to 5.
// - lower strobe serves ports 1 to 7, upper strobe ports 8 to 13.
// - lower address 0 holds hub flags, 1..7 ports 1..7; upper 0..5 ports 8..13.
// - bit 3 carries jabber at lower address 0 and partition at port addresses.
// - rising edge of mode-load reset starts a one second all-LEDs-lit test.
// - no packet repetition while the LED test runs.
// - after a packet ends, displayed activity freezes 30 ms or until next packet.
// - periodic interrupt halts update cycles; they resume once it is serviced.
// - mode-load reset held low keeps all display logic in reset.
// - processor strobe lets the current update finish, then enables the bus buffer.
package ledsd_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned NS_PER_MS        = 1000000;
  localparam int unsigned LED_TEST_TIME_MS = 1000;
  localparam int unsigned STRETCH_TIME_MS  = 30;
  localparam int unsigned LED_TEST_CYCLES  = LED_TEST_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned STRETCH_CYCLES   = STRETCH_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int unsigned PHASE_DIV        = 4;

  localparam int unsigned NUM_PORTS   = 13;
  localparam int unsigned MODE_BIT    = 7;
  localparam logic [3:0]  LOWER_SLOTS = 4'h8;
  localparam logic [3:0]  LAST_SLOT   = 4'hd;

  localparam int unsigned D_LINK   = 0;
  localparam int unsigned D_COL    = 1;
  localparam int unsigned D_REC    = 2;
  localparam int unsigned D_PART   = 3;
  localparam int unsigned D_POL    = 4;
  localparam int unsigned ADDR_LSB = 5;

  localparam logic [7:0] MIN_TEST_MASK  = 8'h1e;
  localparam logic [7:0] HUB_TEST_MASK  = 8'h0e;
  localparam logic [7:0] AUI_TEST_MASK  = 8'h0e;
  localparam logic [7:0] PORT_TEST_MASK = 8'h1f;
  localparam logic [7:0] DATA_RESET     = 8'h00;

  typedef enum logic [1:0] {LEDSD_SETUP, LEDSD_STROBE, LEDSD_HOLD, LEDSD_PAUSE} ledsd_phase_t;

  function automatic logic [2:0] ledsd_bank_addr(input logic [3:0] slot);
    ledsd_bank_addr = (slot < LOWER_SLOTS) ? slot[2:0] : 3'(slot - LOWER_SLOTS);
  endfunction : ledsd_bank_addr

  function automatic logic [3:0] ledsd_port_idx(input logic [3:0] slot);
    ledsd_port_idx = (slot == 4'h0) ? 4'h0 : 4'(slot - 4'h1);
  endfunction : ledsd_port_idx
endpackage : ledsd_pkg

//--- rtl/ledsd_stretch.sv
`timescale 1ns/1ps
`default_nettype none
module ledsd_stretch
  import ledsd_pkg::*;
#(
  parameter int unsigned FREEZE_CYCLES = STRETCH_CYCLES
) (
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 repeat_active_in,
  input  wire logic [NUM_PORTS-1:0] port_collision_in,
  input  wire logic [NUM_PORTS-1:0] port_reception_in,
  output var  logic [NUM_PORTS-1:0] shown_collision_out,
  output var  logic [NUM_PORTS-1:0] shown_reception_out
);
  logic repeat_q;
  logic freeze_busy;
  logic packet_end;

  assign packet_end = repeat_q & ~repeat_active_in;

  // freeze window, cut short by the next packet
  ledsd_timer #(.CYCLES(FREEZE_CYCLES)) u_freeze (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .start_in (packet_end),
    .cancel_in(repeat_active_in),
    .busy_out (freeze_busy)
  );

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      repeat_q <= 1'b0;
    end else begin
      repeat_q <= repeat_active_in;
    end
  end

  // gather activity during a packet, hold it while frozen
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      shown_collision_out <= '0;
      shown_reception_out <= '0;
    end else if (repeat_active_in) begin
      if (!repeat_q) begin
        shown_collision_out <= port_collision_in;
        shown_reception_out <= port_reception_in;
      end else begin
        shown_collision_out <= shown_collision_out | port_collision_in;
        shown_reception_out <= shown_reception_out | port_reception_in;
      end
    end else if (!(freeze_busy || packet_end)) begin
      shown_collision_out <= port_collision_in;
      shown_reception_out <= port_reception_in;
    end
  end
endmodule : ledsd_stretch
`default_nettype wire

//--- rtl/ledsd_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ledsd_timer
  import ledsd_pkg::*;
#(
  parameter int unsigned CYCLES = 16
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic start_in,
  input  wire logic cancel_in,
  output var  logic busy_out
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);

  logic [W-1:0] count;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (start_in) begin
      count <= LOAD;
    end else if (cancel_in) begin
      count <= '0;
    end else if (count != '0) begin
      count <= count - W'(1);
    end
  end

  assign busy_out = (count != '0);
endmodule : ledsd_timer
`default_nettype wire

//--- rtl/ledsd_top.sv
`timescale 1ns/1ps
`default_nettype none
module ledsd_top
  import ledsd_pkg::*;
#(
  parameter int unsigned TEST_CYCLES   = LED_TEST_CYCLES,
  parameter int unsigned FREEZE_CYCLES = STRETCH_CYCLES
) (
  input  wire logic                 CLK_SYS_IN,
  input  wire logic                 NRST_IN,
  input  wire logic                 MODE_LOAD_RESET_N_IN,
  input  wire logic [7:0]           DATA_IN,
  input  wire logic [NUM_PORTS-1:0] PORT_COLLISION_IN,
  input  wire logic [NUM_PORTS-1:0] PORT_RECEPTION_IN,
  input  wire logic [NUM_PORTS-1:0] PORT_PARTITION_IN,
  input  wire logic [NUM_PORTS-1:0] PORT_LINK_IN,
  input  wire logic [NUM_PORTS-1:0] PORT_INVERSE_POLARITY_IN,
  input  wire logic [NUM_PORTS-1:0] PORT_INTERNAL_XCVR_IN,
  input  wire logic                 JABBER_PROTECT_FLAG_IN,
  input  wire logic                 REPEAT_ACTIVE_IN,
  input  wire logic                 PERIODIC_INTERRUPT_IN,
  input  wire logic                 PROC_READ_STROBE_IN,
  input  wire logic                 PROC_WRITE_STROBE_IN,
  output var  logic [7:0]           DATA_OUT,
  output var  logic                 DATA_OE_OUT,
  output var  logic                 LOWER_BANK_STROBE_N_OUT,
  output var  logic                 UPPER_BANK_STROBE_N_OUT,
  output var  logic                 BUS_BUFFER_ENABLE_OUT,
  output var  logic                 REPEAT_INHIBIT_OUT,
  output var  logic                 MAX_MODE_OUT
);
  logic                 rst_n;
  logic                 mode_load_q;
  logic                 mode_load_rise;
  logic                 max_mode;
  logic                 test_busy;
  logic [NUM_PORTS-1:0] shown_col;
  logic [NUM_PORTS-1:0] shown_rec;
  logic                 any_col;
  logic                 any_rec;
  logic                 any_part;
  logic                 proc_req;
  logic                 halt_req;
  logic [1:0]           div_count;
  logic                 tick;
  ledsd_phase_t         phase;
  logic [3:0]           slot;
  logic [3:0]           port_idx;
  logic [2:0]           bank_addr;
  logic                 upper_bank;
  logic [7:0]           next_word;
  logic [7:0]           test_mask;

  // mode-load low holds the display logic in reset
  assign rst_n          = NRST_IN & MODE_LOAD_RESET_N_IN;
  assign mode_load_rise = MODE_LOAD_RESET_N_IN & ~mode_load_q;

  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      mode_load_q <= 1'b0;
    end else begin
      mode_load_q <= MODE_LOAD_RESET_N_IN;
    end
  end

  // configuration bit follows the data bus while mode-load is low, held after release
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      max_mode <= 1'b0;
    end else if (!MODE_LOAD_RESET_N_IN) begin
      max_mode <= DATA_IN[MODE_BIT];
    end
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      MAX_MODE_OUT <= 1'b0;
    end else begin
      MAX_MODE_OUT <= max_mode;
    end
  end

  // LED test timer
  ledsd_timer #(.CYCLES(TEST_CYCLES)) u_test (
    .clk_in   (CLK_SYS_IN),
    .rst_n_in (rst_n),
    .start_in (mode_load_rise),
    .cancel_in(1'b0),
    .busy_out (test_busy)
  );

  always_ff @(posedge CLK_SYS_IN) begin
    if (!rst_n) begin
      REPEAT_INHIBIT_OUT <= 1'b0;
    end else begin
      REPEAT_INHIBIT_OUT <= test_busy | mode_load_rise;
    end
  end

  // activity stretching
  ledsd_stretch #(.FREEZE_CYCLES(FREEZE_CYCLES)) u_stretch (
    .clk_in             (CLK_SYS_IN),
    .rst_n_in           (rst_n),
    .repeat_active_in   (REPEAT_ACTIVE_IN),
    .port_collision_in  (PORT_COLLISION_IN),
    .port_reception_in  (PORT_RECEPTION_IN),
    .shown_collision_out(shown_col),
    .shown_reception_out(shown_rec)
  );

  assign any_col  = |shown_col;
  assign any_rec  = |shown_rec;
  assign any_part = |PORT_PARTITION_IN;

  assign proc_req = PROC_READ_STROBE_IN | PROC_WRITE_STROBE_IN;
  assign halt_req = proc_req | PERIODIC_INTERRUPT_IN;

  // phase rate divider
  always_ff @(posedge CLK_SYS_IN) begin
    if (!rst_n) begin
      div_count <= 2'h0;
    end else if (div_count == 2'(PHASE_DIV - 1)) begin
      div_count <= 2'h0;
    end else begin
      div_count <= div_count + 2'h1;
    end
  end

  assign tick = (div_count == 2'(PHASE_DIV - 1));

  assign port_idx   = ledsd_port_idx(slot);
  assign bank_addr  = ledsd_bank_addr(slot);
  assign upper_bank = max_mode && (slot >= LOWER_SLOTS);

  // word for the current slot
  always_comb begin
    next_word = DATA_RESET;
    test_mask = DATA_RESET;
    if (!max_mode) begin
      next_word[D_COL]  = any_col;
      next_word[D_REC]  = any_rec;
      next_word[D_PART] = JABBER_PROTECT_FLAG_IN;
      next_word[D_POL]  = any_part;
      test_mask         = MIN_TEST_MASK;
    end else if (slot == 4'h0) begin
      next_word[D_COL]  = any_col;
      next_word[D_REC]  = any_rec;
      next_word[D_PART] = JABBER_PROTECT_FLAG_IN;
      test_mask         = HUB_TEST_MASK;
    end else begin
      next_word[D_COL]  = shown_col[port_idx];
      next_word[D_REC]  = shown_rec[port_idx];
      next_word[D_PART] = PORT_PARTITION_IN[port_idx];
      if (slot == 4'h1) begin
        test_mask = AUI_TEST_MASK;
      end else begin
        next_word[D_LINK] = PORT_LINK_IN[port_idx];
        next_word[D_POL]  = PORT_INVERSE_POLARITY_IN[port_idx] & PORT_INTERNAL_XCVR_IN[port_idx];
        test_mask         = PORT_TEST_MASK;
      end
    end
    if (test_busy) begin
      next_word = next_word | test_mask;
    end
    if (max_mode) begin
      next_word[7:ADDR_LSB] = bank_addr;
    end
  end

  // update cycle sequencer
  always_ff @(posedge CLK_SYS_IN) begin
    if (!rst_n) begin
      phase                   <= LEDSD_SETUP;
      slot                    <= 4'h0;
      DATA_OUT                <= DATA_RESET;
      DATA_OE_OUT             <= 1'b0;
      LOWER_BANK_STROBE_N_OUT <= 1'b1;
      UPPER_BANK_STROBE_N_OUT <= 1'b1;
      BUS_BUFFER_ENABLE_OUT   <= 1'b0;
    end else begin
      unique case (phase)
        LEDSD_SETUP: begin
          if (tick) begin
            if (halt_req) begin
              phase <= LEDSD_PAUSE;
            end else begin
              DATA_OUT    <= next_word;
              DATA_OE_OUT <= 1'b1;
              phase       <= LEDSD_STROBE;
            end
          end
        end
        LEDSD_STROBE: begin
          if (tick) begin
            if (upper_bank) begin
              UPPER_BANK_STROBE_N_OUT <= 1'b0;
            end else begin
              LOWER_BANK_STROBE_N_OUT <= 1'b0;
            end
            phase <= LEDSD_HOLD;
          end
        end
        LEDSD_HOLD: begin
          if (tick) begin
            LOWER_BANK_STROBE_N_OUT <= 1'b1;
            UPPER_BANK_STROBE_N_OUT <= 1'b1;
            if (!max_mode || slot == LAST_SLOT) begin
              slot <= 4'h0;
            end else begin
              slot <= slot + 4'h1;
            end
            phase <= LEDSD_SETUP;
          end
        end
        LEDSD_PAUSE: begin
          if (proc_req) begin
            BUS_BUFFER_ENABLE_OUT <= 1'b1;
            DATA_OE_OUT           <= 1'b0;
          end else begin
            BUS_BUFFER_ENABLE_OUT <= 1'b0;
            if (!PERIODIC_INTERRUPT_IN) begin
              phase <= LEDSD_SETUP;
            end
          end
        end
      endcase
    end
  end
endmodule : ledsd_top
`default_nettype wire

//--- verification/led_status_display_update_bench.sv
`timescale 1ns/1ps
`default_nettype none
module led_status_display_update_bench import ledsd_pkg::*; ;
  localparam int unsigned TC = 400;
  localparam int unsigned FC = 200;
  logic        clk, nrst, mlr_n, jabber_protect_flag, rpt, irq, rd, wr, oe, lo_n, up_n, bufen, inh, maxm;
  logic [7:0]  din, dout, bus;
  logic [12:0] col, port_reception, part, link, pol, xcvr;
  logic [7:0]  lq [8];
  logic [7:0]  uq [8];
  int          err_count = 0, cmp_count = 0, cycles = 0, falls = 0;
  // released bus shows the inverse of the last word
  assign bus = oe ? dout : ~dout;
  ledsd_top #(.TEST_CYCLES(TC), .FREEZE_CYCLES(FC)) ledsd_top_inst (
    .CLK_SYS_IN(clk), .NRST_IN(nrst), .MODE_LOAD_RESET_N_IN(mlr_n), .DATA_IN(din),
    .PORT_COLLISION_IN(col), .PORT_RECEPTION_IN(port_reception), .PORT_PARTITION_IN(part), .PORT_LINK_IN(link),
    .PORT_INVERSE_POLARITY_IN(pol), .PORT_INTERNAL_XCVR_IN(xcvr), .JABBER_PROTECT_FLAG_IN(jabber_protect_flag),
    .REPEAT_ACTIVE_IN(rpt), .PERIODIC_INTERRUPT_IN(irq), .PROC_READ_STROBE_IN(rd),
    .PROC_WRITE_STROBE_IN(wr), .DATA_OUT(dout), .DATA_OE_OUT(oe), .LOWER_BANK_STROBE_N_OUT(lo_n),
    .UPPER_BANK_STROBE_N_OUT(up_n), .BUS_BUFFER_ENABLE_OUT(bufen), .REPEAT_INHIBIT_OUT(inh),
    .MAX_MODE_OUT(maxm));
  ledsd_latch_model ledsd_latch_model_inst (.clk_in(clk), .data_in(bus), .lower_strobe_n_in(lo_n),
    .upper_strobe_n_in(up_n), .lower_q_out(lq), .upper_q_out(uq));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (!lo_n || !up_n) begin
      falls <= falls + 1;
    end
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected word at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected flag at %0t: %b not %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  function automatic logic [7:0] exp_max(input int s);
    logic [7:0] w;
    int         p;
    p = s - 1;
    w = {3'((s < 8) ? s : s - 8), 5'h00};
    if (s == 0) begin
      w[3:1] = {jabber_protect_flag, |port_reception, |col};
    end else begin
      w[4:0] = {pol[p] & xcvr[p] & (s > 1), part[p], port_reception[p], col[p], link[p] & (s > 1)};
    end
    return w;
  endfunction : exp_max
  task automatic load_mode(input logic [7:0] cfg);
    cyc(1);
    mlr_n <= 1'b0;
    din <= cfg;
    {rpt, jabber_protect_flag, col, port_reception, part, link, pol, xcvr} <= '0;
    cyc(3);
    #1 chk_bit(oe, 1'b0);
    chk_bit(lo_n & up_n, 1'b1);
    cyc(1);
    mlr_n <= 1'b1;
    cyc(2);
    #1 chk_bit(maxm, cfg[7]);
    chk_bit(inh, 1'b1);
  endtask : load_mode
  task automatic wait_test();
    for (int i = 0; i < TC && inh !== 1'b0; i++) begin
      cyc(1);
    end
    #1 chk_bit(inh, 1'b0);
    cyc(1);
  endtask : wait_test
  task automatic t_min();
    load_mode(8'h00);
    cyc(TC / 2);
    #1 chk_word(lq[0], MIN_TEST_MASK);
    wait_test();
    {col, part, jabber_protect_flag} <= {13'h0008, 13'h0020, 1'b1};
    cyc(1);
    rpt <= 1'b1;
    cyc(40);
    #1 chk_word(lq[0], 8'h1a);
    cyc(1);
    port_reception <= 13'h0100;
    cyc(40);
    #1 chk_word(lq[0], 8'h1e);
    cyc(1);
    {rpt, col, port_reception} <= '0;
    cyc(60);
    #1 chk_word(lq[0], 8'h1e);
    cyc(FC);
    #1 chk_word(lq[0], 8'h18);
    cyc(1);
    {rpt, col} <= {1'b1, 13'h0004};
    cyc(20);
    {rpt, col} <= '0;
    cyc(30);
    rpt <= 1'b1;
    cyc(40);
    #1 chk_word(lq[0], 8'h18);
  endtask : t_min
  task automatic t_max();
    load_mode(8'h80);
    cyc(TC / 2);
    #1 chk_word(lq[0], HUB_TEST_MASK);
    chk_word(lq[1], 8'h20 | AUI_TEST_MASK);
    chk_word(uq[5], 8'ha0 | PORT_TEST_MASK);
    wait_test();
    {col, port_reception, part, link} <= {13'h1555, 13'h0aaa, 13'h0f0f, 13'h1ff0};
    {pol, xcvr, jabber_protect_flag} <= {13'h1fff, 13'h0ff0, 1'b1};
    cyc(1);
    rpt <= 1'b1;
    cyc(400);
    #1;
    for (int s = 0; s < 14; s++) begin
      chk_word((s < 8) ? lq[s] : uq[s - 8], exp_max(s));
    end
  endtask : t_max
  task automatic t_halt();
    int f;
    cyc(1);
    irq <= 1'b1;
    cyc(20);
    f = falls;
    cyc(40);
    #1 chk_bit(falls == f, 1'b1);
    cyc(1);
    irq <= 1'b0;
    cyc(40);
    #1 chk_bit(falls > f, 1'b1);
  endtask : t_halt
  task automatic t_access(input logic w);
    cyc(1);
    {wr, rd} <= {w, !w};
    for (int i = 0; i < 20 && bufen !== 1'b1; i++) begin
      cyc(1);
    end
    #1 chk_bit(bufen, 1'b1);
    chk_bit(oe, 1'b0);
    cyc(1);
    {wr, rd} <= '0;
    cyc(2);
    #1 chk_bit(bufen, 1'b0);
  endtask : t_access
  initial begin
    {nrst, mlr_n, jabber_protect_flag, rpt, irq, rd, wr, din} = '0;
    {col, port_reception, part, link, pol, xcvr} = '0;
    cyc(8);
    nrst <= 1'b1;
    t_min();
    t_max();
    t_halt();
    t_access(1'b0);
    t_access(1'b1);
    conclude();
  end
endmodule : led_status_display_update_bench
`default_nettype wire

//--- verification/ledsd_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ledsd_checker
  import ledsd_pkg::*;
#(
  parameter int unsigned TEST_CYCLES = 40
) (
  input wire logic       CLK_SYS_IN,
  input wire logic       NRST_IN,
  input wire logic       MODE_LOAD_RESET_N_IN,
  input wire logic       PERIODIC_INTERRUPT_IN,
  input wire logic       PROC_READ_STROBE_IN,
  input wire logic       PROC_WRITE_STROBE_IN,
  input wire logic [7:0] DATA_OUT,
  input wire logic       DATA_OE_OUT,
  input wire logic       LOWER_BANK_STROBE_N_OUT,
  input wire logic       UPPER_BANK_STROBE_N_OUT,
  input wire logic       BUS_BUFFER_ENABLE_OUT,
  input wire logic       REPEAT_INHIBIT_OUT,
  input wire logic       MAX_MODE_OUT
);
  wire logic   lo = LOWER_BANK_STROBE_N_OUT;
  wire logic   up = UPPER_BANK_STROBE_N_OUT;
  wire logic   acc = PROC_READ_STROBE_IN || PROC_WRITE_STROBE_IN;
  int unsigned cnt;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN || !MODE_LOAD_RESET_N_IN);
  // length of the current led test
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN || !MODE_LOAD_RESET_N_IN || !REPEAT_INHIBIT_OUT) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  property p_width(logic s);
    $fell(s) |-> (!s)[*4] ##1 s;
  endproperty
  a_min_upper_idle: assert property (!MAX_MODE_OUT |-> up) else $error("upper strobe in min mode");
  a_min_word: assert property (!MAX_MODE_OUT && !lo |-> DATA_OUT[7:5] == 3'h0 && !DATA_OUT[0])
    else $error("min word unused bits set");
  a_one_bank: assert property (lo || up) else $error("both strobes low");
  a_upper_addr: assert property (MAX_MODE_OUT && !up |-> DATA_OUT[7:5] <= 3'h5)
    else $error("upper address out of range");
  a_lower_width: assert property (p_width(lo)) else $error("lower strobe width");
  a_upper_width: assert property (p_width(up)) else $error("upper strobe width");
  a_data_during: assert property (!lo || !up |-> $stable(DATA_OUT)) else $error("data moved in strobe");
  a_data_after: assert property ($rose(lo) || $rose(up) |-> $stable(DATA_OUT)[*4])
    else $error("data moved after strobe");
  a_test_start: assert property ($rose(MODE_LOAD_RESET_N_IN) |=> REPEAT_INHIBIT_OUT)
    else $error("led test not started");
  a_test_len: assert property ($fell(REPEAT_INHIBIT_OUT) |-> cnt + 1 >= TEST_CYCLES && cnt <= TEST_CYCLES + 1)
    else $error("led test length");
  a_test_max: assert property (cnt <= TEST_CYCLES + 1) else $error("led test too long");
  a_irq_halt: assert property (PERIODIC_INTERRUPT_IN[*8] ##1 PERIODIC_INTERRUPT_IN[*8] |-> lo && up)
    else $error("update during interrupt");
  a_grant_wait: assert property ($rose(acc) |-> ##[1:16] BUS_BUFFER_ENABLE_OUT) else $error("no grant");
  a_grant_cause: assert property (BUS_BUFFER_ENABLE_OUT |-> $past(acc) && !DATA_OE_OUT && lo && up)
    else $error("grant without access");
  c_lower: cover property ($fell(lo));
  c_upper: cover property ($fell(up));
  c_grant: cover property ($rose(BUS_BUFFER_ENABLE_OUT));
endmodule : ledsd_checker
bind ledsd_top ledsd_checker #(.TEST_CYCLES(TEST_CYCLES)) ledsd_checker_inst (
  .CLK_SYS_IN(CLK_SYS_IN), .NRST_IN(NRST_IN), .MODE_LOAD_RESET_N_IN(MODE_LOAD_RESET_N_IN),
  .PERIODIC_INTERRUPT_IN(PERIODIC_INTERRUPT_IN), .PROC_READ_STROBE_IN(PROC_READ_STROBE_IN),
  .PROC_WRITE_STROBE_IN(PROC_WRITE_STROBE_IN), .DATA_OUT(DATA_OUT), .DATA_OE_OUT(DATA_OE_OUT),
  .LOWER_BANK_STROBE_N_OUT(LOWER_BANK_STROBE_N_OUT), .UPPER_BANK_STROBE_N_OUT(UPPER_BANK_STROBE_N_OUT),
  .BUS_BUFFER_ENABLE_OUT(BUS_BUFFER_ENABLE_OUT), .REPEAT_INHIBIT_OUT(REPEAT_INHIBIT_OUT),
  .MAX_MODE_OUT(MAX_MODE_OUT));
`default_nettype wire

//--- verification/ledsd_latch_model.sv
`timescale 1ns/1ps
`default_nettype none
module ledsd_latch_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] data_in,
  input  wire logic       lower_strobe_n_in,
  input  wire logic       upper_strobe_n_in,
  output var  logic [7:0] lower_q_out [8],
  output var  logic [7:0] upper_q_out [8]
);
  // addressed output loads while its bank strobe is low, holds otherwise
  always_ff @(posedge clk_in) begin
    if (!lower_strobe_n_in) begin
      lower_q_out[data_in[7:5]] <= data_in;
    end
    if (!upper_strobe_n_in) begin
      upper_q_out[data_in[7:5]] <= data_in;
    end
  end
endmodule : ledsd_latch_model
`default_nettype wire
